// ### bench/pefr_assertions.sv
`timescale 1ns/1ns
module pefr_assertions #(
    parameter pefr_pkg::pefr_variant_t VARIANT = pefr_pkg::PEFR_SERIAL
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic sync_done_i,
    input wire logic timer_ovf_i,
    input wire logic parport_access_i,
    input wire logic serial_rx_read_o,
    input wire logic serial_tx_write_o,
    input wire logic [7:0] periph_event_flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_shape: assert property (s_req |-> s_ack)
        else $error("ack not a pulse after request");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Range covers the two sync stages, the flag register and the output register
    a_ovf_set: assert property ($rose(timer_ovf_i) |-> ##[3:4] periph_event_flags_o[0])
        else $error("overflow flag not set");
    a_sync_set: assert property ($rose(sync_done_i) |-> ##[3:4] periph_event_flags_o[3])
        else $error("sync flag not set");
    a_ovf_sticky: assert property ($fell(periph_event_flags_o[0]) |->
        $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
        else $error("overflow flag fell without write");
    a_resv_zero: assert property (!periph_event_flags_o[6] &&
        (VARIANT == pefr_pkg::PEFR_PARPORT || !periph_event_flags_o[7]))
        else $error("reserved flag bits set");
    a_par_unimpl: assert property (VARIANT == pefr_pkg::PEFR_SERIAL ||
        periph_event_flags_o[5:4] == 2'b00)
        else $error("unimplemented flag bits set");
    a_par_set: assert property (VARIANT == pefr_pkg::PEFR_PARPORT &&
        $rose(parport_access_i) |-> ##[3:4] periph_event_flags_o[7])
        else $error("port access flag not set");
    a_rx_pop: assert property (serial_rx_read_o |-> wb_ack_o && !wb_we_i)
        else $error("rx pop without read");
    a_tx_load: assert property (serial_tx_write_o |-> wb_ack_o && wb_we_i)
        else $error("tx load without write");
endmodule // pefr_assertions
bind pefr_top pefr_assertions #(.VARIANT(VARIANT)) i_chk (.*);

// ### bench/pefr_top_tb_top.sv
`timescale 1ns/1ns
module pefr_top_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, w;
    logic wb_ack_o, serial_rx_read_o, serial_tx_write_o;
    logic [7:0] ev = 8'h00;
    logic [7:0] periph_event_flags_o;
    logic [7:0] p_flags;
    logic [31:0] expq[$];
    int n_mismatch = 0;
    int total_checks = 0;
    pefr_top i_dut (.*, .sync_done_i(ev[3]), .capture_i(ev[2]), .compare_match_i(ev[6]),
        .period_match_i(ev[1]), .timer_ovf_i(ev[0]), .parport_access_i(ev[7]),
        .rx_data_avail_i(ev[5]), .tx_data_taken_i(ev[4]));
    // Parallel-port variant shares the bus and pins; only its flag view is compared
    pefr_top #(.VARIANT(pefr_pkg::PEFR_PARPORT)) i_dut_par (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
        .sync_done_i(ev[3]), .capture_i(ev[2]), .compare_match_i(ev[6]),
        .period_match_i(ev[1]), .timer_ovf_i(ev[0]), .parport_access_i(ev[7]),
        .rx_data_avail_i(ev[5]), .tx_data_taken_i(ev[4]), .serial_rx_read_o(),
        .serial_tx_write_o(), .periph_event_flags_o(p_flags));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (expq.size() != 0) begin
            n_mismatch++;
        end
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'h1);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Level held long enough to pass the input synchroniser
    task automatic fire(input int b);
        @(posedge clk_i);
        ev[b] <= 1'b1;
        repeat (3) @(posedge clk_i);
        ev[b] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
            check(wb_dat_o, expq.pop_front());
    end
    initial begin
        w = $urandom(32'hdd6c2c22);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        check({24'h00_0000, periph_event_flags_o}, 32'h0000_0000);
        rd(8'h0c, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        $display("reset test done");
        for (int b = 0; b < 4; b++)
            fire(b);
        rd(8'h0c, 32'h0000_000f);
        w = $urandom();
        bus(1'b1, 8'h0c, w & 32'h0000_003f);
        rd(8'h0c, {28'h000_0000, w[3:0]});
        check({24'h00_0000, periph_event_flags_o}, {28'h000_0000, w[3:0]});
        bus(1'b1, 8'h0c, 32'h0000_0000);
        bus(1'b1, 8'h0c, 32'h0000_003f);
        rd(8'h0c, 32'h0000_0000);
        $display("event test done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h10, 32'(m));
            fire(m[0] ? 6 : 2);
            rd(8'h0c, (m < 2) ? 32'h0000_0004 : 32'h0000_0000);
            bus(1'b1, 8'h0c, 32'h0000_0000);
        end
        $display("mode test done");
        fire(4);
        fire(5);
        bus(1'b1, 8'h0c, 32'h0000_0000);
        rd(8'h0c, 32'h0000_0030);
        check({24'h00_0000, p_flags}, 32'h0000_0000);
        rd(8'h14, 32'h0000_0003);
        rd(8'h0c, 32'h0000_0010);
        bus(1'b1, 8'h10, 32'h0000_5500, 4'h2);
        rd(8'h0c, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        $display("serial test done");
        fire(7);
        check({24'h00_0000, p_flags}, 32'h0000_0080);
        check({24'h00_0000, periph_event_flags_o}, 32'h0000_0000);
        bus(1'b1, 8'h0c, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        check({24'h00_0000, p_flags}, 32'h0000_0000);
        $display("port test done");
        complete_run();
    end
endmodule // pefr_top_tb_top

// ### hw/pefr_flag_core.sv
`timescale 1ns/1ns
`include "pefr_cfg.svh"
module pefr_flag_core (
    input wire logic clk_i,
    input wire logic rst_i,
    pefr_ev_if.core ev
);
    logic [7:0] flags;
    logic [7:0] next_flags;
    assign ev.flags = flags;
    // Set beats clear in the same cycle so no event is lost
    always_comb begin
        next_flags = (flags & ~ev.clr) | ev.set;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= `PEFR_FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end
endmodule // pefr_flag_core

// ### hw/pefr_sync.sv
`timescale 1ns/1ns
module pefr_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule // pefr_sync

// ### hw/pefr_top.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "pefr_cfg.svh"
// Overview of operation
// - Flags set on their event regardless of any enable bit.
// - Parallel-port variant reads bits 5 and 4 as zero.
// - All bits are zero after reset.
// - Bit 3 set on sync port transfer done, cleared by software.
// - Capture mode: bit 2 set on timer capture, software clears.
// - Compare mode: bit 2 set on compare match, software clears.
// - In PWM mode the unit does not set bit 2.
// - Bit 1 set on short timer period match, software clears.
// - Bit 0 set on wide timer overflow, software clears.
// - Parallel variant: bit 7 set on external port access.
// - Serial variant: bit 5 shows receive full, clears on data read.
// - Serial variant: bit 4 shows transmit empty, clears on data write.
module pefr_top #(
    parameter pefr_pkg::pefr_variant_t VARIANT = pefr_pkg::PEFR_SERIAL
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sync_done_i,
    input wire logic capture_i,
    input wire logic compare_match_i,
    input wire logic period_match_i,
    input wire logic timer_ovf_i,
    input wire logic parport_access_i,
    input wire logic rx_data_avail_i,
    input wire logic tx_data_taken_i,
    output logic serial_rx_read_o,
    output logic serial_tx_write_o,
    output logic [7:0] periph_event_flags_o
);
    import pefr_pkg::*;

    pefr_ev_if ev ();

    logic [7:0] raw;
    logic [7:0] pins_s;
    logic [6:0] evs;
    logic [6:0] evs_d;
    logic [6:0] next_evs_d;
    logic [6:0] rise;
    logic [1:0] ccmode;
    logic [1:0] next_ccmode;
    logic rx_full;
    logic next_rx_full;
    logic tx_empty;
    logic next_tx_empty;
    logic ack;
    logic next_ack;
    logic [31:0] rdat;
    logic [31:0] next_rdat;
    logic rx_rd;
    logic next_rx_rd;
    logic tx_wr;
    logic next_tx_wr;
    logic [7:0] flags_out;
    logic [7:0] next_flags_out;
    logic req;
    logic wr_flags;
    logic rd_rxdata;
    logic wr_txdata;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] view;

    // Pin events come from other domains and are edge-detected after sync
    assign raw = {compare_match_i, tx_data_taken_i, rx_data_avail_i, parport_access_i,
                  sync_done_i, timer_ovf_i, period_match_i, capture_i};

    pefr_sync #(.W(8)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(raw),
        .q_o(pins_s)
    );

    // Capture and compare are merged only after the flops, so no gate sees a raw pin
    assign evs = {pins_s[6:1], pins_s[7] | pins_s[0]};

    pefr_flag_core u_core (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ev(ev)
    );

    assign rise = evs & ~evs_d;
    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr_flags = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PEFR_FLAGS_OFS);
    // Reading byte 0 of the status word pops the receive data
    assign rd_rxdata = req & ~wb_we_i & wb_sel_i[0] & (wb_adr_i == `PEFR_STAT_OFS);
    // Writing byte 1 of the control word loads transmit data
    assign wr_txdata = req & wb_we_i & wb_sel_i[1] & (wb_adr_i == `PEFR_CTRL_OFS);

    always_comb begin
        set_v = 8'h00;
        clr_v = 8'h00;
        // Flags set from events with no enable bit; only bit 2 is gated, by the capture/compare mode
        set_v[`PEFR_BIT_TMR_OVF] = rise[2];
        set_v[`PEFR_BIT_PER_MATCH] = rise[1];
        // Capture/compare flag only in matching mode, never in PWM
        set_v[`PEFR_BIT_CAPCMP] = rise[0] &
            ((ccmode == PEFR_CAPTURE) | (ccmode == PEFR_COMPARE));
        set_v[`PEFR_BIT_SYNC] = rise[3];
        if (VARIANT == PEFR_PARPORT) begin
            set_v[`PEFR_BIT_PARPORT] = rise[4];
        end
        // Software may only clear writable flags; reserved and read-only bits ignored
        if (wr_flags) begin
            clr_v = ~wb_dat_i[7:0] & `PEFR_SW_MASK;
        end
    end

    assign ev.set = set_v;
    assign ev.clr = clr_v;

    always_comb begin
        view = ev.flags;
        if (VARIANT == PEFR_SERIAL) begin
            view[`PEFR_BIT_RX_FULL] = rx_full;
            view[`PEFR_BIT_TX_EMPTY] = tx_empty;
            view = view & `PEFR_SER_MASK;
        end else begin
            view = view & `PEFR_PAR_MASK;
        end
    end

    always_comb begin
        next_evs_d = evs;
        next_ccmode = ccmode;
        next_rx_full = rx_full;
        next_tx_empty = tx_empty;
        next_ack = req;
        next_rdat = 32'h0000_0000;
        next_rx_rd = 1'b0;
        next_tx_wr = 1'b0;
        next_flags_out = view;
        if (req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PEFR_CTRL_OFS)) begin
            next_ccmode = wb_dat_i[1:0];
        end
        if (VARIANT == PEFR_SERIAL) begin
            // Arrival wins over a same-cycle read so a new byte is not hidden
            if (rd_rxdata) begin
                next_rx_full = 1'b0;
                next_rx_rd = 1'b1;
            end
            if (rise[5]) begin
                next_rx_full = 1'b1;
            end
            if (wr_txdata) begin
                next_tx_empty = 1'b0;
                next_tx_wr = 1'b1;
            end
            if (rise[6]) begin
                next_tx_empty = 1'b1;
            end
        end
        if (req & ~wb_we_i) begin
            case (wb_adr_i)
                `PEFR_FLAGS_OFS: next_rdat = {24'h00_0000, view};
                `PEFR_CTRL_OFS: next_rdat = {30'h0000_0000, ccmode};
                `PEFR_STAT_OFS: next_rdat = {30'h0000_0000, tx_empty, rx_full};
                default: next_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evs_d <= 7'h00;
            ccmode <= `PEFR_MODE_RESET;
            rx_full <= 1'b0;
            tx_empty <= 1'b0;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
            rx_rd <= 1'b0;
            tx_wr <= 1'b0;
            flags_out <= `PEFR_FLAGS_RESET;
        end else begin
            evs_d <= next_evs_d;
            ccmode <= next_ccmode;
            rx_full <= next_rx_full;
            tx_empty <= next_tx_empty;
            ack <= next_ack;
            rdat <= next_rdat;
            rx_rd <= next_rx_rd;
            tx_wr <= next_tx_wr;
            flags_out <= next_flags_out;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign serial_rx_read_o = rx_rd;
    assign serial_tx_write_o = tx_wr;
    assign periph_event_flags_o = flags_out;
endmodule // pefr_top

// ### inc/pefr_cfg.svh
`ifndef PEFR_CFG_SVH
`define PEFR_CFG_SVH
`define PEFR_FLAGS_OFS 8'h0c
`define PEFR_CTRL_OFS 8'h10
`define PEFR_STAT_OFS 8'h14
`define PEFR_BIT_TMR_OVF 0
`define PEFR_BIT_PER_MATCH 1
`define PEFR_BIT_CAPCMP 2
`define PEFR_BIT_SYNC 3
`define PEFR_BIT_TX_EMPTY 4
`define PEFR_BIT_RX_FULL 5
`define PEFR_BIT_PARPORT 7
`define PEFR_FLAGS_RESET 8'h00
`define PEFR_MODE_RESET 2'h0
`define PEFR_SER_MASK 8'h3f
`define PEFR_PAR_MASK 8'h8f
`define PEFR_SW_MASK 8'h8f
`endif

// ### inc/pefr_ev_if.sv
`timescale 1ns/1ns
interface pefr_ev_if;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] flags;
    modport core (input set, input clr, output flags);
    modport ctrl (output set, output clr, input flags);
endinterface

// ### inc/pefr_pkg.sv
package pefr_pkg;
    typedef enum logic [1:0] {
        PEFR_CAPTURE,
        PEFR_COMPARE,
        PEFR_PWM,
        PEFR_OFF
    } pefr_ccmode_t;
    typedef enum logic [0:0] {
        PEFR_SERIAL,
        PEFR_PARPORT
    } pefr_variant_t;
endpackage
